// >>> shared/eye_scan_pkg.sv
// Constants for the eye monitor scan controller.
// Assumes a 125 MHz clock and a 32-bit APB register port.
package eye_scan_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_DWELL_HI = 16'h0054;
  localparam logic [15:0] IDX_DWELL_LO = 16'h0055;
  localparam logic [15:0] IDX_THRESH = 16'h0056;
  localparam logic [15:0] IDX_CTRL = 16'h0058;
  localparam logic [15:0] IDX_STAT = 16'h0059;
  localparam logic [15:0] IDX_PH_RANGE = 16'h005A;
  localparam logic [15:0] IDX_PH_STEP_VB = 16'h005B;
  localparam logic [15:0] IDX_VE_STEP = 16'h005C;
  localparam logic [15:0] IDX_SIZE = 16'h005D;
  localparam logic [15:0] IDX_SHAPE_H = 16'h005E;
  localparam logic [15:0] IDX_SHAPE_V = 16'h005F;
  localparam logic [15:0] IDX_HDR_ROW = 16'h6CC1;
  localparam logic [15:0] IDX_HDR_SIZE = 16'h6CC2;
  localparam logic [15:0] IDX_DATA = 16'h6CC3;
  // Reset values
  localparam logic [15:0] RST_DWELL_HI = 16'h0000;
  localparam logic [15:0] RST_DWELL_LO = 16'h0064;
  localparam logic [15:0] RST_THRESH = 16'h0001;
  localparam logic [15:0] RST_PH_RANGE = 16'h7F00;
  localparam logic [15:0] RST_PH_STEP_VB = 16'h0000;
  localparam logic [15:0] RST_VE_STEP = 16'h00FF;
  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SHAPE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_END_BIT = 2;
  localparam int PH_BEGIN_LSB = 0;
  localparam int PH_END_LSB = 8;
  localparam int PH_STRIDE_LSB = 0;
  localparam int VT_BEGIN_LSB = 8;
  localparam int VT_END_LSB = 0;
  localparam int VT_STRIDE_LSB = 8;
  // Grid and segment geometry
  localparam int SEG_SAMPLES = 256;
  localparam logic [15:0] HDR_BYTES = 16'h0004;
  localparam logic [6:0] PH_LAST = 7'h7F;
  localparam logic [7:0] VT_LAST = 8'hFF;
  localparam logic [6:0] SHAPE_PH_CENTRE = 7'h40;
  localparam logic [7:0] SHAPE_VT_CENTRE = 8'h80;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE, ST_MEAS, ST_STORE, ST_HOLD, ST_RESUME, ST_END
  } state_type;
endpackage : eye_scan_pkg

// >>> design/eye_scan_ctrl.sv
// Eye monitor scan controller: grid sweep, dwell timing, error
// counting, segmented scan buffer and APB register slave.
// Assumes the sampler front end pulses one error per cycle at most.
//
// How it works
// [R1] Default settings sweep all 128 phases by 256 offsets.
// [R2] Start/stop indices shrink the area; three stride values (1, 2, 4) per axis.
// [R3] Six spatial fields: phase and vertical begin, end, stride.
// [R4] Dwell time in microseconds from two 16-bit halves.
// [R5] Per-point error counter is 16 bits and saturates.
// [R6] Results go out in segments of at most 516 bytes.
// [R7] Full scan gives 128 segments of two 128-sample lines.
// [R8] Partial scans pack lines, partial ones too, into segments.
// [R9] Grid phase origin caught at monitor power-up, kept while powered.
// [R10] Shape scan reports left, right, top and bottom of eye.
// [R11] Point fails when its errors reach the threshold in dwell.
// [R12] Scan-type bit: 1 runs shape scan, 0 runs matrix scan.
// [R13] Start, done, start cleared, done cleared handshake.
// [R14] Host restores spatial defaults before a shape scan.
// [R15] Image size register holds last segment size in bytes.
// [R16] Buffer headers: last offset row, size copy, then samples.
// [R17] Host reads header onward up to half the image size.
// [R18] Samples two bytes each, left to right, top to bottom.
// [R19] Sample count equals image size minus four, halved.
// [R20] Host finishes power-up before enabling the monitor.
// [R21] Host may scan only the centre row for jitter.
// [R22] Done set per segment; next waits for start cleared.
// [R23] Host changes configuration only while idle.
`timescale 1ns/1ps
`default_nettype none
module eye_scan_ctrl #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Sampler front end
  input wire logic I_MONITOR_POWER,
  input wire logic I_SAMPLE_ERROR,
  output logic O_SCAN_ACTIVE,
  output logic [6:0] O_SAMPLE_PHASE,
  output logic [7:0] O_SAMPLE_OFFSET
);
  localparam int DIV_W = $clog2(eye_scan_pkg::CYC_PER_US);
  localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(eye_scan_pkg::CYC_PER_US - 1);

  logic rst_meta_r;
  logic rst_n_r;
  logic [15:0] dwell_hi_r;
  logic [15:0] dwell_lo_r;
  logic [15:0] thresh_r;
  logic [15:0] ph_range_r;
  logic [15:0] ph_step_vb_r;
  logic [15:0] ve_step_r;
  logic start_r;
  logic shape_r;
  logic [31:0] prdata_r;
  logic err_r;
  eye_scan_pkg::state_type state_r;
  logic shape_run_r;
  logic sweep_r;
  logic [6:0] ph_r;
  logic [7:0] vt_r;
  logic [8:0] fill_r;
  logic [DIV_W-1:0] div_r;
  logic [31:0] us_r;
  logic [15:0] cnt_r;
  logic [15:0] size_r;
  logic [7:0] hdr_row_r;
  logic [15:0] mem_r [eye_scan_pkg::SEG_SAMPLES];
  logic seen_r;
  logic [6:0] left_r;
  logic [6:0] right_r;
  logic [7:0] top_r;
  logic [7:0] bottom_r;
  logic pwr_q_r;
  logic [6:0] free_r;
  logic [6:0] origin_r;
  logic [6:0] phase_out_r;

  function automatic logic [2:0] stride(input logic [1:0] code);
    case (code)
      2'h0: stride = 3'h1;
      2'h1: stride = 3'h2;
      default: stride = 3'h4;
    endcase
  endfunction : stride

  // Reset release synchroniser
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // [R3] Spatial field decode
  logic [6:0] ph_begin;
  logic [6:0] ph_end;
  logic [2:0] ph_stride;
  logic [7:0] vt_begin;
  logic [7:0] vt_end;
  logic [2:0] vt_stride;
  assign ph_begin = ph_range_r[eye_scan_pkg::PH_BEGIN_LSB +: 7];
  assign ph_end = ph_range_r[eye_scan_pkg::PH_END_LSB +: 7];
  // [R2] Nine stride combinations
  assign ph_stride = stride(ph_step_vb_r[eye_scan_pkg::PH_STRIDE_LSB +: 2]);
  assign vt_begin = ph_step_vb_r[eye_scan_pkg::VT_BEGIN_LSB +: 8];
  assign vt_end = ve_step_r[eye_scan_pkg::VT_END_LSB +: 8];
  assign vt_stride = stride(ve_step_r[eye_scan_pkg::VT_STRIDE_LSB +: 2]);

  // Next grid position
  logic [7:0] ph_sum;
  logic [8:0] vt_sum;
  logic ph_wrap;
  logic mat_last;
  logic shape_last;
  logic seg_full;
  logic point_fail;
  logic [15:0] seg_size;
  assign ph_sum = {1'b0, ph_r} + {5'h00, ph_stride};
  assign vt_sum = {1'b0, vt_r} + {6'h00, vt_stride};
  assign ph_wrap = ph_sum > {1'b0, ph_end};
  // [R1] Sweep ends after last row and column
  assign mat_last = ph_wrap && (vt_sum > {1'b0, vt_end});
  assign shape_last = sweep_r && (vt_r == eye_scan_pkg::VT_LAST);
  // [R6] Segment closes at 256 samples
  assign seg_full = fill_r == 9'(eye_scan_pkg::SEG_SAMPLES - 1);
  // [R11] Fail when errors reach threshold
  assign point_fail = cnt_r >= thresh_r;
  // [R19] Size counts header bytes plus two per sample
  assign seg_size = {6'h00, fill_r + 9'h001, 1'b0} + eye_scan_pkg::HDR_BYTES;

  // Microsecond tick and dwell end
  logic us_tick;
  logic meas_end;
  assign us_tick = (state_r == eye_scan_pkg::ST_MEAS) && (div_r == DIV_TOP);
  // [R4] Dwell from both halves
  assign meas_end = us_tick && ({1'b0, us_r} + 33'h1 >= {1'b0, dwell_hi_r, dwell_lo_r});

  // Scan sequencer
  always_ff @(posedge I_CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= eye_scan_pkg::ST_IDLE;
      shape_run_r <= 1'b0;
      sweep_r <= 1'b0;
      ph_r <= 7'h00;
      vt_r <= 8'h00;
      fill_r <= 9'h000;
    end
    else
    begin
      unique case (state_r)
        eye_scan_pkg::ST_IDLE:
        begin
          // [R13] Host start opens the scan
          if (start_r)
          begin
            // [R12] Type bit picks shape or matrix
            shape_run_r <= shape_r;
            sweep_r <= 1'b0;
            fill_r <= 9'h000;
            ph_r <= shape_r ? 7'h00 : ph_begin;
            vt_r <= shape_r ? eye_scan_pkg::SHAPE_VT_CENTRE : vt_begin;
            state_r <= eye_scan_pkg::ST_MEAS;
          end
        end
        eye_scan_pkg::ST_MEAS:
        begin
          if (meas_end)
          begin
            state_r <= eye_scan_pkg::ST_STORE;
          end
        end
        eye_scan_pkg::ST_STORE:
        begin
          if (shape_run_r)
          begin
            // [R10] Centre row, then centre column
            if (shape_last)
            begin
              state_r <= eye_scan_pkg::ST_END;
            end
            else
            begin
              state_r <= eye_scan_pkg::ST_MEAS;
              if (sweep_r)
              begin
                vt_r <= vt_r + 8'h01;
              end
              else if (ph_r == eye_scan_pkg::PH_LAST)
              begin
                sweep_r <= 1'b1;
                ph_r <= eye_scan_pkg::SHAPE_PH_CENTRE;
                vt_r <= 8'h00;
              end
              else
              begin
                ph_r <= ph_r + 7'h01;
              end
            end
          end
          else if (mat_last)
          begin
            state_r <= eye_scan_pkg::ST_END;
          end
          else
          begin
            // [R18] Phase inner, offset outer
            if (ph_wrap)
            begin
              ph_r <= ph_begin;
              vt_r <= vt_sum[7:0];
            end
            else
            begin
              ph_r <= ph_sum[6:0];
            end
            // [R8] Lines may straddle segments
            if (seg_full)
            begin
              state_r <= eye_scan_pkg::ST_HOLD;
            end
            else
            begin
              fill_r <= fill_r + 9'h001;
              state_r <= eye_scan_pkg::ST_MEAS;
            end
          end
        end
        eye_scan_pkg::ST_HOLD:
        begin
          // [R22] Wait for host to drop start
          if (!start_r)
          begin
            fill_r <= 9'h000;
            state_r <= eye_scan_pkg::ST_RESUME;
          end
        end
        eye_scan_pkg::ST_RESUME:
        begin
          if (start_r)
          begin
            state_r <= eye_scan_pkg::ST_MEAS;
          end
        end
        eye_scan_pkg::ST_END:
        begin
          // [R13] Done clears once start is dropped
          if (!start_r)
          begin
            state_r <= eye_scan_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Dwell timer and error counter
  always_ff @(posedge I_CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      div_r <= '0;
      us_r <= 32'h0000_0000;
      cnt_r <= 16'h0000;
    end
    else if (state_r == eye_scan_pkg::ST_MEAS)
    begin
      div_r <= us_tick ? '0 : div_r + 1'b1;
      if (us_tick)
      begin
        us_r <= us_r + 32'h0000_0001;
      end
      // [R5] Saturating 16-bit count
      if (I_SAMPLE_ERROR && cnt_r != 16'hFFFF)
      begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
    else if (state_r == eye_scan_pkg::ST_STORE || state_r == eye_scan_pkg::ST_IDLE)
    begin
      div_r <= '0;
      us_r <= 32'h0000_0000;
      cnt_r <= 16'h0000;
    end
  end

  // Segment header values
  always_ff @(posedge I_CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      size_r <= 16'h0000;
      hdr_row_r <= 8'h00;
    end
    else if (state_r == eye_scan_pkg::ST_STORE && !shape_run_r)
    begin
      // [R16] Last offset row stored
      hdr_row_r <= vt_r;
      // [R15] Size of the segment just closed
      if (seg_full || mat_last)
      begin
        size_r <= seg_size;
      end
    end
  end

  // [R7] Scan buffer, one word per sample
  genvar gi;
  generate
    for (gi = 0; gi < eye_scan_pkg::SEG_SAMPLES; gi++)
    begin : g_buf
      always_ff @(posedge I_CLOCK or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          mem_r[gi] <= 16'h0000;
        end
        else if (state_r == eye_scan_pkg::ST_STORE && !shape_run_r
                 && fill_r == 9'(gi))
        begin
          mem_r[gi] <= cnt_r;
        end
      end
    end
  endgenerate

  // Shape scan boundary capture
  always_ff @(posedge I_CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      seen_r <= 1'b0;
      left_r <= 7'h00;
      right_r <= 7'h00;
      top_r <= 8'h00;
      bottom_r <= 8'h00;
    end
    else if (state_r == eye_scan_pkg::ST_IDLE && start_r && shape_r)
    begin
      seen_r <= 1'b0;
    end
    else if (state_r == eye_scan_pkg::ST_STORE && shape_run_r)
    begin
      // [R11] Boundaries follow pass/fail
      if (!sweep_r && ph_r == eye_scan_pkg::PH_LAST)
      begin
        seen_r <= 1'b0;
      end
      else if (!point_fail)
      begin
        seen_r <= 1'b1;
      end
      if (!point_fail && !sweep_r)
      begin
        if (!seen_r)
        begin
          left_r <= ph_r;
        end
        right_r <= ph_r;
      end
      if (!point_fail && sweep_r)
      begin
        if (!seen_r)
        begin
          top_r <= vt_r;
        end
        bottom_r <= vt_r;
      end
    end
  end

  // [R9] Phase origin fixed at power-up
  always_ff @(posedge I_CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pwr_q_r <= 1'b0;
      free_r <= 7'h00;
      origin_r <= 7'h00;
      phase_out_r <= 7'h00;
    end
    else
    begin
      pwr_q_r <= I_MONITOR_POWER;
      free_r <= free_r + 7'h01;
      if (I_MONITOR_POWER && !pwr_q_r)
      begin
        origin_r <= free_r;
      end
      phase_out_r <= ph_r + origin_r;
    end
  end

  assign O_SCAN_ACTIVE = state_r == eye_scan_pkg::ST_MEAS;
  assign O_SAMPLE_PHASE = phase_out_r;
  assign O_SAMPLE_OFFSET = vt_r;

  // APB decode
  logic [15:0] idx;
  logic [15:0] buf_off;
  logic setup;
  logic wr_en;
  assign idx = 16'(I_PADDR[ADDR_W-1:2]);
  assign buf_off = idx - eye_scan_pkg::IDX_DATA;
  assign setup = I_PSEL && !I_PENABLE;
  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;

  // Configuration and control registers
  always_ff @(posedge I_CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      dwell_hi_r <= eye_scan_pkg::RST_DWELL_HI;
      dwell_lo_r <= eye_scan_pkg::RST_DWELL_LO;
      thresh_r <= eye_scan_pkg::RST_THRESH;
      ph_range_r <= eye_scan_pkg::RST_PH_RANGE;
      ph_step_vb_r <= eye_scan_pkg::RST_PH_STEP_VB;
      ve_step_r <= eye_scan_pkg::RST_VE_STEP;
      start_r <= 1'b0;
      shape_r <= 1'b0;
    end
    else if (wr_en)
    begin
      case (idx)
        eye_scan_pkg::IDX_DWELL_HI: dwell_hi_r <= I_PWDATA[15:0];
        eye_scan_pkg::IDX_DWELL_LO: dwell_lo_r <= I_PWDATA[15:0];
        eye_scan_pkg::IDX_THRESH: thresh_r <= I_PWDATA[15:0];
        eye_scan_pkg::IDX_PH_RANGE: ph_range_r <= I_PWDATA[15:0];
        eye_scan_pkg::IDX_PH_STEP_VB: ph_step_vb_r <= I_PWDATA[15:0];
        eye_scan_pkg::IDX_VE_STEP: ve_step_r <= I_PWDATA[15:0];
        eye_scan_pkg::IDX_CTRL:
        begin
          start_r <= I_PWDATA[eye_scan_pkg::CTRL_START_BIT];
          shape_r <= I_PWDATA[eye_scan_pkg::CTRL_SHAPE_BIT];
        end
        default: ;
      endcase
    end
  end

  // Read mux
  logic [15:0] rd_val;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    case (idx)
      eye_scan_pkg::IDX_DWELL_HI: rd_val = dwell_hi_r;
      eye_scan_pkg::IDX_DWELL_LO: rd_val = dwell_lo_r;
      eye_scan_pkg::IDX_THRESH: rd_val = thresh_r;
      eye_scan_pkg::IDX_PH_RANGE: rd_val = ph_range_r;
      eye_scan_pkg::IDX_PH_STEP_VB: rd_val = ph_step_vb_r;
      eye_scan_pkg::IDX_VE_STEP: rd_val = ve_step_r;
      eye_scan_pkg::IDX_CTRL:
      begin
        rd_val[eye_scan_pkg::CTRL_START_BIT] = start_r;
        rd_val[eye_scan_pkg::CTRL_SHAPE_BIT] = shape_r;
      end
      eye_scan_pkg::IDX_STAT:
      begin
        rd_val[eye_scan_pkg::STAT_BUSY_BIT] = state_r != eye_scan_pkg::ST_IDLE;
        rd_val[eye_scan_pkg::STAT_DONE_BIT] = state_r == eye_scan_pkg::ST_HOLD
                                              || state_r == eye_scan_pkg::ST_END;
        rd_val[eye_scan_pkg::STAT_END_BIT] = state_r == eye_scan_pkg::ST_END;
      end
      eye_scan_pkg::IDX_SIZE: rd_val = size_r;
      eye_scan_pkg::IDX_SHAPE_H: rd_val = {1'b0, right_r, 1'b0, left_r};
      eye_scan_pkg::IDX_SHAPE_V: rd_val = {bottom_r, top_r};
      eye_scan_pkg::IDX_HDR_ROW: rd_val = {8'h00, hdr_row_r};
      eye_scan_pkg::IDX_HDR_SIZE: rd_val = size_r;
      default:
      begin
        if (idx >= eye_scan_pkg::IDX_DATA && buf_off < 16'(eye_scan_pkg::SEG_SAMPLES))
        begin
          rd_val = mem_r[buf_off[7:0]];
        end
        else
        begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // Read data and error captured in setup phase
  always_ff @(posedge I_CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= I_PWRITE ? 32'h0000_0000 : {16'h0000, rd_val};
      err_r <= !rd_hit;
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && err_r;
endmodule : eye_scan_ctrl
`default_nettype wire

// >>> dv/eye_scan_asserts.sv
// Port checker for the eye scan controller.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
module eye_scan_asserts #(
  parameter int ADDR_W = 18
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_SCAN_ACTIVE,
  input wire logic [7:0] O_SAMPLE_OFFSET
);
  logic [15:0] idx;
  logic mapped;
  logic [31:0] run_q;
  default clocking dcb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESET_N);
  assign idx = 16'(I_PADDR[ADDR_W-1:2]);
  assign mapped = (idx >= eye_scan_pkg::IDX_DWELL_HI && idx <= eye_scan_pkg::IDX_SHAPE_V
    && idx != 16'h0057) || (idx >= eye_scan_pkg::IDX_HDR_ROW && idx <= 16'h6DC2);
  // Length of the current measuring run
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      run_q <= 32'h0;
    else
      run_q <= O_SCAN_ACTIVE ? run_q + 32'h1 : 32'h0;
  end
  ready_always_a: assert property (O_PREADY)
    else $error("pready low");
  slverr_in_access_a: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
    else $error("pslverr outside access phase");
  slverr_decode_a: assert property (I_PSEL && I_PENABLE |-> O_PSLVERR == !mapped)
    else $error("pslverr does not match address decode");
  unmapped_zero_a: assert property (I_PSEL && I_PENABLE && !mapped |-> O_PRDATA == 32'h0)
    else $error("unmapped read data not zero");
  upper_zero_a: assert property (O_PRDATA[31:16] == 16'h0)
    else $error("read data upper half not zero");
  rdata_hold_a: assert property (!($past(I_PSEL) && !$past(I_PENABLE)) |-> $stable(O_PRDATA))
    else $error("read data changed outside setup");
  offset_hold_a: assert property (
    O_SCAN_ACTIVE && $past(O_SCAN_ACTIVE) |-> $stable(O_SAMPLE_OFFSET))
    else $error("offset moved within a point");
  dwell_len_a: assert property (
    !O_SCAN_ACTIVE && run_q != 32'h0 |-> run_q % eye_scan_pkg::CYC_PER_US == 0)
    else $error("measuring run not whole microseconds");
  reset_quiet_a: assert property ($rose(I_RESET_N) |-> !O_SCAN_ACTIVE [*3])
    else $error("scan active right after reset");
endmodule : eye_scan_asserts
bind eye_scan_ctrl eye_scan_asserts #(.ADDR_W(ADDR_W)) chk (.I_CLOCK(I_CLOCK),
  .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_SCAN_ACTIVE(O_SCAN_ACTIVE), .O_SAMPLE_OFFSET(O_SAMPLE_OFFSET));
`default_nettype wire

// >>> dv/eye_scan_ctrl_tb.sv
// Self-checking bench for the eye scan controller.
// Drives APB and the sampler error line itself; no far-side model.
`timescale 1ns/1ps
`default_nettype none
module eye_scan_ctrl_tb;
  logic clk, rst_n, psel, penable, pwrite, pwr, pready, pslverr, active, err_line, slv;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] phase, ph_a, ph_b;
  logic [7:0] offset;
  logic [1:0] inj;
  int errors, total_checks;
  logic [15:0] ridx [6] = '{eye_scan_pkg::IDX_DWELL_HI, eye_scan_pkg::IDX_DWELL_LO,
    eye_scan_pkg::IDX_THRESH, eye_scan_pkg::IDX_PH_RANGE, eye_scan_pkg::IDX_PH_STEP_VB,
    eye_scan_pkg::IDX_VE_STEP};
  logic [15:0] rval [6] = '{eye_scan_pkg::RST_DWELL_HI, eye_scan_pkg::RST_DWELL_LO,
    eye_scan_pkg::RST_THRESH, eye_scan_pkg::RST_PH_RANGE, eye_scan_pkg::RST_PH_STEP_VB,
    eye_scan_pkg::RST_VE_STEP};
  // Phases 0..4 stride 2, offsets 1..3 stride 1: nine points
  logic [15:0] cval [3] = '{16'h0400, 16'h0101, 16'h0003};

  eye_scan_ctrl #(.ADDR_W(18)) dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_MONITOR_POWER(pwr),
    .I_SAMPLE_ERROR(err_line), .O_SCAN_ACTIVE(active), .O_SAMPLE_PHASE(phase),
    .O_SAMPLE_OFFSET(offset));

  // Sampler reflex: errors on the middle row, or outside the shape window
  assign err_line = (inj == 2'd1 && offset == 8'h02)
    || (inj == 2'd2 && (offset < 8'h20 || offset > 8'hE0));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    check("pready", 33'h1, {32'h0, pready});
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [15:0] idx, input logic [15:0] exp, input string what);
    apb(1'b0, idx, 16'h0000);
    check(what, {17'h0, exp}, {slv, rd});
  endtask : rchk

  task automatic scan(input logic shape, input logic last, output logic [6:0] ph);
    int n;
    n = 0;
    apb(1'b1, eye_scan_pkg::IDX_CTRL, {14'h0, shape, 1'b1});
    repeat (5) @(posedge clk);
    ph = phase;
    check("scan active", 33'h1, {32'h0, active});
    rd = 32'h0;
    while (rd[1] !== 1'b1 && n < 30000)
    begin
      apb(1'b0, eye_scan_pkg::IDX_STAT, 16'h0000);
      n++;
    end
    check("scan done", {31'h0, last, 1'b1}, {31'h0, rd[2:1]});
  endtask : scan

  task automatic release_start();
    int n;
    n = 0;
    apb(1'b1, eye_scan_pkg::IDX_CTRL, 16'h0000);
    rd = 32'h2;
    while (rd[1] !== 1'b0 && n < 100)
    begin
      apb(1'b0, eye_scan_pkg::IDX_STAT, 16'h0000);
      n++;
    end
    check("done cleared", 33'h0, {32'h0, rd[1]});
  endtask : release_start

  initial
  begin
    #790000;
    errors++;
    end_of_test();
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, pwr, paddr, pwdata, inj} = '0;
    errors = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    pwr <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++)
      rchk(ridx[i], rval[i], "reset value");
    apb(1'b1, 16'h0057, 16'hFFFF);
    check("unmapped write", {1'b1, 32'h0}, {slv, rd});
    apb(1'b0, 16'h0000, 16'h0000);
    check("unmapped read", {1'b1, 32'h0}, {slv, rd});
    apb(1'b1, eye_scan_pkg::IDX_DWELL_HI, 16'hA5A5);
    rchk(eye_scan_pkg::IDX_DWELL_HI, 16'hA5A5, "dwell high");
    apb(1'b1, eye_scan_pkg::IDX_DWELL_HI, 16'h0000);
    apb(1'b1, eye_scan_pkg::IDX_DWELL_LO, 16'h0001);
    rchk(eye_scan_pkg::IDX_DWELL_LO, 16'h0001, "dwell low");
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, ridx[i + 3], cval[i]);
      rchk(ridx[i + 3], cval[i], "spatial field");
    end
    inj <= 2'd1;
    scan(1'b0, 1'b1, ph_a);
    rchk(eye_scan_pkg::IDX_SIZE, 16'd22, "image size");
    rchk(eye_scan_pkg::IDX_HDR_ROW, 16'h0003, "last row");
    rchk(eye_scan_pkg::IDX_HDR_SIZE, 16'd22, "size copy");
    for (int k = 0; k < 9; k++)
      rchk(16'(eye_scan_pkg::IDX_DATA + k), (k / 3 == 1) ? 16'h007D : 16'h0000,
        "sample");
    release_start();
    check("idle busy", 33'h0, {32'h0, rd[0]});
    apb(1'b1, eye_scan_pkg::IDX_HDR_SIZE, 16'hBEEF);
    rchk(eye_scan_pkg::IDX_HDR_SIZE, 16'd22, "read-only copy");
    inj <= 2'd0;
    // Centre offset only: one horizontal line, phase stride 4
    apb(1'b1, eye_scan_pkg::IDX_PH_RANGE, 16'h7F00);
    apb(1'b1, eye_scan_pkg::IDX_PH_STEP_VB, 16'h8002);
    apb(1'b1, eye_scan_pkg::IDX_VE_STEP, 16'h0080);
    scan(1'b0, 1'b1, ph_b);
    check("phase origin", {26'h0, ph_a}, {26'h0, ph_b});
    rchk(eye_scan_pkg::IDX_SIZE, 16'd68, "line size");
    rchk(eye_scan_pkg::IDX_HDR_ROW, 16'h0080, "line row");
    rchk(16'(eye_scan_pkg::IDX_DATA + 4), 16'h0000, "fresh count");
    release_start();
    // Spatial defaults back before the shape scan
    for (int i = 3; i < 6; i++)
      apb(1'b1, ridx[i], rval[i]);
    inj <= 2'd2;
    scan(1'b1, 1'b1, ph_b);
    rchk(eye_scan_pkg::IDX_SHAPE_H, 16'h7F00, "shape width");
    rchk(eye_scan_pkg::IDX_SHAPE_V, 16'hE020, "shape height");
    release_start();
    inj <= 2'd0;
    scan(1'b0, 1'b0, ph_b);
    rchk(eye_scan_pkg::IDX_SIZE, 16'd516, "segment size");
    rchk(eye_scan_pkg::IDX_HDR_ROW, 16'h0001, "segment row");
    release_start();
    apb(1'b1, eye_scan_pkg::IDX_CTRL, 16'h0001);
    apb(1'b0, eye_scan_pkg::IDX_STAT, 16'h0000);
    check("next segment busy", 33'h1, {32'h0, rd[0]});
    // Second reset in mid-scan
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(eye_scan_pkg::IDX_DWELL_LO, eye_scan_pkg::RST_DWELL_LO, "dwell after reset");
    end_of_test();
  end
endmodule : eye_scan_ctrl_tb
`default_nettype wire
